/* File: hdl/ecf_pkg.sv */
// constants, field layouts and types of the enclave instruction checker
// assumes a 32-bit classic wishbone register port on a single clock
package ecf_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [4:0] OFS_CTX = 5'h00;
    localparam logic [4:0] OFS_BMLO = 5'h04;
    localparam logic [4:0] OFS_BMHI = 5'h08;
    localparam logic [4:0] OFS_ACC = 5'h0c;
    localparam logic [4:0] OFS_ISSUE = 5'h10;
    localparam logic [4:0] OFS_RESULT = 5'h14;
    localparam logic [4:0] OFS_LEAF = 5'h18;

    // ==========================================================
    // reset values
    localparam logic [31:0] CTX_RST = 32'h0000_0000;
    localparam logic [63:0] BM_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic [31:0] ISSUE_RST = 32'h0000_0000;
    localparam logic [31:0] LEAF_RST = 32'h0000_0000;

    // ==========================================================
    // context register fields
    localparam int POS_PROT = 0;
    localparam int POS_PAGING = 1;
    localparam int POS_NUMERR = 2;
    localparam int POS_TASKSW = 3;
    localparam int POS_V86 = 4;
    localparam int POS_SYSMGMT = 5;
    localparam int POS_TXN = 6;
    localparam int POS_LONG = 7;
    localparam int POS_CS64 = 8;
    localparam int POS_CSDEF = 9;
    localparam int POS_DSBIG = 10;
    localparam int POS_DSDOWN = 11;
    localparam int POS_PRIV = 12;
    localparam int POS_FLOCK = 14;
    localparam int POS_ENCL_EN = 15;
    localparam int POS_IN_ENCL = 16;
    localparam int POS_BASECAP = 17;
    localparam int POS_OVERSUB = 18;
    localparam int POS_VMXOP = 19;
    localparam int POS_GUEST = 20;
    localparam int POS_EXEC_EN = 21;
    localparam int POS_EXIT_CTL = 22;

    // ==========================================================
    // issue register fields
    localparam int POS_OPC = 0;
    localparam int POS_LOCK = 24;
    localparam int POS_OPSZ = 25;
    localparam int POS_REP = 26;
    localparam int POS_VEX = 27;
    localparam int POS_SEGOV = 28;
    localparam int POS_ASZ = 29;
    localparam int POS_REX = 30;

    // ==========================================================
    // result register fields
    localparam int POS_R_OUT = 0;
    localparam int POS_R_BUSY = 3;
    localparam int POS_R_M64 = 4;
    localparam int POS_R_HYP = 5;
    localparam int POS_R_DSSEG = 6;

    // ==========================================================
    // opcodes and leaf indices
    localparam logic [23:0] OPC_USER = 24'h0f_01d7;
    localparam logic [23:0] OPC_HYP = 24'h0f_01c0;
    localparam logic [31:0] LEAF_REPORT = 32'h0000_0000;
    localparam logic [31:0] LEAF_KEY = 32'h0000_0001;
    localparam logic [31:0] LEAF_ENTRY = 32'h0000_0002;
    localparam logic [31:0] LEAF_RESUME = 32'h0000_0003;
    localparam logic [31:0] LEAF_EXIT = 32'h0000_0004;
    localparam logic [31:0] LEAF_ACCEPT = 32'h0000_0005;
    localparam logic [31:0] LEAF_PERM_EXT = 32'h0000_0006;
    localparam logic [31:0] LEAF_ACC_COPY = 32'h0000_0007;
    localparam logic [31:0] LEAF_BM_LAST = 32'h0000_003e;
    localparam logic [63:0] USER_LEAF_MASK = 64'h0000_0000_0000_00ff;
    localparam logic [63:0] HYP_LEAF_MASK = 64'h0000_0000_0000_0007;

    // outcome of one qualification
    typedef enum logic [2:0] {
        OUT_NONE, OUT_DISPATCH, OUT_UD, OUT_GP, OUT_NM, OUT_TX_ABORT,
        OUT_VM_EXIT
    } ecf_outcome_t;

    // leaf index supported by a mask
    function automatic logic ecf_leaf_ok(input logic [63:0] mask,
                                         input logic [31:0] idx);
        ecf_leaf_ok = (idx < 32'h0000_0040) && mask[idx[5:0]];
    endfunction : ecf_leaf_ok

    // byte-lane merge of a write
    function automatic logic [31:0] ecf_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
        for (int i = 0; i < 4; i++)
        begin
            ecf_merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : ecf_merge

endpackage : ecf_pkg

/* File: hdl/ecf_wb_port.sv */
// classic wishbone slave handshake for the checker registers
// assumes master holds a request until ack; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module ecf_wb_port
    import ecf_pkg::*;
(
    input wire logic mclk, // core clock
    input wire logic reset, // sync reset, high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [31:0] wb_adr_i, // byte address
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic [31:0] reg_rdata, // register read value
    output logic reg_wr, // write takes effect now
    output logic [4:0] reg_ofs, // word-aligned byte offset
    output logic reg_hit // address inside the map
);

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ecf_wb_state_t;

    ecf_wb_state_t st;
    ecf_wb_state_t next_st;
    logic req;

    // address decode and write strobe on the ack edge
    assign req = wb_cyc_i && wb_stb_i;
    assign reg_ofs = {wb_adr_i[4:2], 2'b00};
    assign reg_hit = (wb_adr_i[31:5] == 27'h000_0000);
    assign reg_wr = st.ack && req && wb_we_i;
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.dat;

    // ack one cycle after request, dropped the cycle after
    always_comb
    begin
        next_st = st;
        next_st.ack = req && !st.ack;
        if (req && !st.ack)
        begin
            next_st.dat = wb_we_i ? 32'h0000_0000 : reg_rdata;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : ecf_wb_port
`default_nettype wire

/* File: hdl/ecf_opcode_decode.sv */
// opcode and prefix classification of an issued instruction
// assumes the issue word is held stable by the caller
`timescale 1ns/1ps
`default_nettype none
module ecf_opcode_decode
    import ecf_pkg::*;
(
    input wire logic [31:0] issue, // opcode bytes and prefix flags
    output logic is_user, // user-level enclave instruction
    output logic is_hyp, // hypervisor-level enclave instruction
    output logic bad_prefix // forbidden prefix present
);

    // opcode match, no mandatory prefix
    assign is_user = (issue[POS_OPC +: 24] == OPC_USER);
    assign is_hyp = (issue[POS_OPC +: 24] == OPC_HYP);

    // segment, address-size and rex flags are never looked at
    assign bad_prefix = issue[POS_LOCK] || issue[POS_OPSZ]
        || issue[POS_REP] || issue[POS_VEX];

endmodule : ecf_opcode_decode
`default_nettype wire

/* File: hdl/ecf_enclave_check.sv */
// qualification checks for the user and hypervisor enclave instructions
// assumes software loads context registers before writing the issue word
//
// Overview of operation
// - opcode 0f 01 d7 without mandatory prefix is the user instruction.
// - leaf comes from the accumulator low 32 bits only.
// - user: no protection, v86, system management or no base cap: ud.
// - user below privilege 3 gives ud.
// - user with task switched set gives nm, after mode checks.
// - user with paging or numeric error off gives gp zero.
// - feature lock or enclave enable clear gives gp zero.
// - undefined or unsupported leaf gives gp zero.
// - active transaction region aborts before any other check.
// - 64-bit width only in long 64-bit code; ds forms addresses.
// - user outside 64-bit with 16-bit code or data gives gp.
// - inside enclave, entry or resume leaf gives gp.
// - outside enclave, leaves 0, 1, 4 to 7 give gp.
// - segment, address-size and rex prefixes are ignored.
// - lock, operand-size, repeat or vex prefix gives ud.
// - hypervisor instruction without oversubscription cap gives ud.
// - hypervisor: no protection, v86, system mgmt or no vmx: ud.
// - hypervisor above privilege 0 gives ud.
// - hypervisor in guest with 64-bit long code gives ud.
// - hypervisor in guest with execution enable clear gives ud.
// - exiting control set: bitmap bit of leaf, 63 above 62, exits.
// - hypervisor: paging off or expand-down ds outside 64-bit: gp.
// - hypervisor unrecognized in real and v86 mode.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ecf_enclave_check
    import ecf_pkg::*;
(
    input wire logic mclk, // core clock, 25 MHz
    input wire logic reset, // sync reset, high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [31:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic dispatch_valid, // pulse: leaf flow starts
    output logic [31:0] dispatch_leaf, // leaf index handed on
    output logic dispatch_hyp, // hypervisor instruction was checked
    output logic fault_valid, // pulse: check ended in fault or exit
    output logic [2:0] fault_kind // outcome code
);

    // ==========================================================
    // types and state

    typedef enum logic [3:0] {
        S_IDLE, S_TXN, S_PREFIX, S_MODE, S_TASK, S_GUEST64, S_PRIV,
        S_VMX, S_FEAT, S_LEAF, S_PAGING, S_SEG, S_ENCL
    } ecf_state_t;

    typedef struct packed {
        ecf_state_t state;
        logic [31:0] ctx;
        logic [63:0] bm;
        logic [31:0] acc;
        logic [31:0] issue;
        ecf_outcome_t outcome;
        logic hyp;
        logic [31:0] leaf;
        logic disp;
        logic flt;
    } ecf_core_t;

    ecf_core_t st;
    ecf_core_t next_st;

    logic reg_wr;
    logic [4:0] reg_ofs;
    logic reg_hit;
    logic [31:0] reg_rdata;
    logic is_user;
    logic is_hyp;
    logic bad_prefix;
    logic busy;
    logic mode64;
    logic [1:0] priv;
    logic in_encl;
    logic bm_hit;

    // ==========================================================
    // bus port and decoder

    ecf_wb_port u_port (
        .mclk(mclk),
        .reset(reset),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .reg_rdata(reg_rdata),
        .reg_wr(reg_wr),
        .reg_ofs(reg_ofs),
        .reg_hit(reg_hit)
    );

    ecf_opcode_decode u_dec (
        .issue(st.issue),
        .is_user(is_user),
        .is_hyp(is_hyp),
        .bad_prefix(bad_prefix)
    );

    // ==========================================================
    // context decode

    // 64-bit mode needs long mode and a 64-bit code segment
    assign mode64 = st.ctx[POS_LONG] && st.ctx[POS_CS64];
    assign priv = st.ctx[POS_PRIV +: 2];
    assign in_encl = st.ctx[POS_IN_ENCL];
    assign busy = (st.state != S_IDLE);

    // exiting bitmap lookup, bit 63 covers every index above 62
    assign bm_hit = (st.acc > LEAF_BM_LAST) ? st.bm[63]
        : st.bm[st.acc[5:0]];

    // outputs straight from flops
    assign dispatch_valid = st.disp;
    assign dispatch_leaf = st.leaf;
    assign dispatch_hyp = st.hyp;
    assign fault_valid = st.flt;
    assign fault_kind = st.outcome;

    // ==========================================================
    // register read mux, unmapped reads as zero

    always_comb
    begin
        reg_rdata = 32'h0000_0000;
        if (reg_hit)
        begin
            case (reg_ofs)
                OFS_CTX: reg_rdata = st.ctx;
                OFS_BMLO: reg_rdata = st.bm[31:0];
                OFS_BMHI: reg_rdata = st.bm[63:32];
                OFS_ACC: reg_rdata = st.acc;
                OFS_ISSUE: reg_rdata = st.issue;
                OFS_RESULT:
                begin
                    reg_rdata[POS_R_OUT +: 3] = st.outcome;
                    reg_rdata[POS_R_BUSY] = busy;
                    reg_rdata[POS_R_M64] = mode64;
                    reg_rdata[POS_R_HYP] = st.hyp;
                    reg_rdata[POS_R_DSSEG] = 1'b1;
                end
                OFS_LEAF: reg_rdata = st.leaf;
                default: reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // register writes and the check sequence

    always_comb
    begin
        logic fail;
        ecf_outcome_t code;
        fail = 1'b0;
        code = OUT_NONE;
        next_st = st;
        next_st.disp = 1'b0;
        next_st.flt = 1'b0;

        // writes land only while idle, so a check sees a frozen context
        if (reg_wr && reg_hit && !busy)
        begin
            case (reg_ofs)
                OFS_CTX: next_st.ctx = ecf_merge(st.ctx, wb_dat_i, wb_sel_i);
                OFS_BMLO:
                begin
                    next_st.bm[31:0] = ecf_merge(st.bm[31:0], wb_dat_i,
                                                 wb_sel_i);
                end
                OFS_BMHI:
                begin
                    next_st.bm[63:32] = ecf_merge(st.bm[63:32], wb_dat_i,
                                                  wb_sel_i);
                end
                // only the low half of the accumulator is kept
                OFS_ACC:
                begin
                    next_st.acc = ecf_merge(st.acc, wb_dat_i,
                                            wb_sel_i);
                end
                OFS_ISSUE:
                begin
                    next_st.issue = ecf_merge(ISSUE_RST, wb_dat_i, wb_sel_i);
                    next_st.state = S_TXN;
                    next_st.outcome = OUT_NONE;
                end
                default: next_st.state = st.state;
            endcase
        end

        // one check a cycle in priority order
        unique case (st.state)
            S_IDLE: next_st.hyp = st.hyp;
            S_TXN:
            begin
                next_st.hyp = is_hyp;
                fail = st.ctx[POS_TXN];
                code = OUT_TX_ABORT;
                next_st.state = S_PREFIX;
            end
            S_PREFIX:
            begin
                // unknown opcode is also undefined
                fail = bad_prefix || !(is_user || is_hyp);
                code = OUT_UD;
                next_st.state = S_MODE;
            end
            S_MODE:
            begin
                fail = !st.ctx[POS_PROT] || st.ctx[POS_V86]
                    || st.ctx[POS_SYSMGMT];
                if (is_user)
                begin
                    fail = fail || !st.ctx[POS_BASECAP];
                end
                else
                begin
                    fail = fail || !st.ctx[POS_OVERSUB]
                        || !st.ctx[POS_VMXOP];
                end
                code = OUT_UD;
                next_st.state = S_TASK;
            end
            S_TASK:
            begin
                fail = is_user && st.ctx[POS_TASKSW];
                code = OUT_NM;
                next_st.state = S_GUEST64;
            end
            S_GUEST64:
            begin
                fail = is_hyp && st.ctx[POS_GUEST] && mode64;
                code = OUT_UD;
                next_st.state = S_PRIV;
            end
            S_PRIV:
            begin
                if (is_user)
                begin
                    fail = (priv != 2'd3);
                end
                else
                begin
                    fail = (priv != 2'd0);
                end
                code = OUT_UD;
                next_st.state = S_VMX;
            end
            S_VMX:
            begin
                if (is_hyp && st.ctx[POS_GUEST] && !st.ctx[POS_EXEC_EN])
                begin
                    fail = 1'b1;
                    code = OUT_UD;
                end
                else if (is_hyp && st.ctx[POS_GUEST]
                         && st.ctx[POS_EXIT_CTL] && bm_hit)
                begin
                    fail = 1'b1;
                    code = OUT_VM_EXIT;
                end
                next_st.state = S_FEAT;
            end
            S_FEAT:
            begin
                fail = !st.ctx[POS_FLOCK] || !st.ctx[POS_ENCL_EN];
                code = OUT_GP;
                next_st.state = S_LEAF;
            end
            S_LEAF:
            begin
                fail = !ecf_leaf_ok(is_user ? USER_LEAF_MASK
                                    : HYP_LEAF_MASK, st.acc);
                code = OUT_GP;
                next_st.state = S_PAGING;
            end
            S_PAGING:
            begin
                fail = !st.ctx[POS_PAGING];
                if (is_user)
                begin
                    fail = fail || !st.ctx[POS_NUMERR];
                end
                code = OUT_GP;
                next_st.state = S_SEG;
            end
            S_SEG:
            begin
                if (is_user)
                begin
                    fail = !mode64 && (!st.ctx[POS_CSDEF]
                        || !st.ctx[POS_DSBIG]);
                end
                else
                begin
                    fail = !mode64 && st.ctx[POS_DSDOWN];
                end
                code = OUT_GP;
                next_st.state = S_ENCL;
            end
            S_ENCL:
            begin
                if (is_user && in_encl)
                begin
                    fail = (st.acc == LEAF_ENTRY)
                        || (st.acc == LEAF_RESUME);
                end
                else if (is_user)
                begin
                    fail = (st.acc == LEAF_REPORT)
                        || (st.acc == LEAF_KEY) || (st.acc == LEAF_EXIT)
                        || (st.acc == LEAF_ACCEPT)
                        || (st.acc == LEAF_PERM_EXT)
                        || (st.acc == LEAF_ACC_COPY);
                end
                code = OUT_GP;
                next_st.state = S_IDLE;
            end
        endcase

        // first failure ends the sequence, else the leaf is handed on
        if (fail)
        begin
            next_st.state = S_IDLE;
            next_st.outcome = code;
            next_st.flt = 1'b1;
        end
        else if (st.state == S_ENCL)
        begin
            next_st.outcome = OUT_DISPATCH;
            next_st.leaf = st.acc;
            next_st.disp = 1'b1;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st <= '{state: S_IDLE, ctx: CTX_RST, bm: BM_RST,
                    acc: ACC_RST, issue: ISSUE_RST, outcome: OUT_NONE,
                    hyp: 1'b0, leaf: LEAF_RST, disp: 1'b0, flt: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : ecf_enclave_check
`default_nettype wire

/* File: dv/ecf_checker.sv */
// port assertions of the enclave instruction checker
// assumes the bench issues a check only while the unit is idle
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// checker module
module ecf_checker
    import ecf_pkg::*;
(
    input wire logic mclk, // core clock
    input wire logic reset, // sync reset, high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [31:0] wb_adr_i, // byte address
    input wire logic wb_ack_o, // acknowledge
    input wire logic dispatch_valid, // leaf flow pulse
    input wire logic [31:0] dispatch_leaf, // leaf handed on
    input wire logic fault_valid, // fault pulse
    input wire logic [2:0] fault_kind // outcome code
);
    logic [3:0] cnt; // cycles since the issue edge
    // count from the accepted issue write
    always_ff @(posedge mclk)
    begin
        if (reset)
            cnt <= 4'h0;
        else if (wb_ack_o && wb_we_i && wb_adr_i == 32'h0000_0010)
            cnt <= 4'h1;
        else if (cnt != 4'hf)
            cnt <= cnt + 4'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    a_pulse_excl: assert property (
        !(fault_valid && dispatch_valid)) else $error("two outcomes");
    a_fault_win: assert property (
        fault_valid |-> cnt >= 4'h2 && cnt <= 4'hd)
        else $error("fault out of window");
    a_disp_time: assert property (dispatch_valid |-> cnt == 4'hd)
        else $error("dispatch mistimed");
    a_disp_kind: assert property (
        dispatch_valid |-> fault_kind == 3'h1) else $error("dispatch code");
    a_fault_code: assert property (
        fault_valid |-> fault_kind inside {[3'h2:3'h6]})
        else $error("fault code");
    a_fault_once: assert property (fault_valid |=>
        (!fault_valid && !dispatch_valid) [*8]) else $error("extra pulse");
    a_leaf_hold: assert property (
        !dispatch_valid |-> $stable(dispatch_leaf)) else $error("leaf moved");
    a_kind_hold: assert property ($changed(fault_kind)
        |-> fault_valid || dispatch_valid || cnt == 4'h1)
        else $error("code moved");
endmodule : ecf_checker
bind ecf_enclave_check ecf_checker u_chk (.mclk, .reset, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .dispatch_valid,
    .dispatch_leaf, .fault_valid, .fault_kind);
`default_nettype wire

/* File: dv/ecf_enclave_check_tb.sv */
// random and directed checks of the unit against a bench model
// assumes the checker file binds itself to the unit
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// testbench
module ecf_enclave_check_tb
    import ecf_pkg::*;
;
    logic mclk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, dleaf, last = 32'h0;
    logic [3:0] sel = 4'hf;
    logic ack, dv, dhyp, fv;
    logic [2:0] fkind;
    int n_fail = 0, cmp_count = 0, seed = 32'h3a87;
    always #20 mclk = ~mclk;
    ecf_enclave_check uut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .dispatch_valid(dv), .dispatch_leaf(dleaf), .dispatch_hyp(dhyp),
        .fault_valid(fv), .fault_kind(fkind));
    // verdict and end of run
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // compare and count
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {26'h0, a};
        dat <= d;
        sel <= 4'hf;
        do
        begin
            @(posedge mclk);
            t++;
        end
        while (ack !== 1'b1 && t < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask : wb
    // expected outcome, first failing check wins
    function automatic logic [2:0] model(input logic [31:0] c, a, i,
                                         input logic [63:0] b);
        logic u, h, m;
        u = i[23:0] == 24'h0f_01d7;
        h = i[23:0] == 24'h0f_01c0;
        m = c[7] & c[8];
        if (c[6]) return 3'h5;
        if (!(u | h) || i[27:24] != 4'h0) return 3'h2;
        if (!c[0] || c[4] || c[5] || (u ? !c[17] : !(c[18] && c[19])))
            return 3'h2;
        if (u && c[3]) return 3'h4;
        if (h && c[20] && m) return 3'h2;
        if (c[13:12] != (u ? 2'h3 : 2'h0)) return 3'h2;
        if (h && c[20] && !c[21]) return 3'h2;
        if (h && c[20] && c[22] && b[(a > 62) ? 6'h3f : a[5:0]])
            return 3'h6;
        if (!c[14] || !c[15]) return 3'h3;
        if (a > (u ? 7 : 2)) return 3'h3;
        if (!c[1] || (u && !c[2])) return 3'h3;
        if (!m && (u ? !(c[9] && c[10]) : c[11])) return 3'h3;
        if (u && (c[16] == (a == 2 || a == 3))) return 3'h3;
        return 3'h1;
    endfunction : model
    // load context, issue, await outcome, read status
    task automatic run(input logic [31:0] c, a, i, input logic [63:0] b);
        logic [31:0] q;
        logic [2:0] k;
        int t;
        k = model(c, a, i, b);
        wb(1'b1, 6'h00, c, q);
        wb(1'b1, 6'h04, b[31:0], q);
        wb(1'b1, 6'h08, b[63:32], q);
        wb(1'b1, 6'h0c, a, q);
        wb(1'b1, 6'h10, i, q);
        t = 0;
        while (fv !== 1'b1 && dv !== 1'b1 && t < 20)
        begin
            @(posedge mclk);
            t++;
        end
        chk({31'h0, fv | dv}, 32'h0000_0001);
        chk({29'h0, fkind}, {29'h0, k});
        if (k == 3'h1)
        begin
            last = a;
            chk(dleaf, a);
            chk({31'h0, dhyp}, {31'h0, i[7:0] == 8'hc0});
        end
        wb(1'b0, 6'h14, 32'h0, q);
        chk({26'h0, q[6], q[4:0]},
            {26'h0, 1'b1, c[7] & c[8], 1'b0, k});
        wb(1'b0, 6'h18, 32'h0, q);
        chk(q, last);
    endtask : run
    // main sequence
    initial
    begin
        logic [31:0] c, a, i, q;
        logic [63:0] b;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        wb(1'b0, 6'h00, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, 6'h20, 32'h0, q);
        chk(q, 32'h0);
        for (int n = 0; n < 400; n++)
        begin
            c = n[0] ? 32'h000c_c003 ^ ($random(seed) & 32'h0070_0980)
                     : 32'h0003_f607 ^ ($random(seed) & 32'h0001_0180);
            if ($random(seed) & 1)
                c = c ^ (32'h1 << ({$random(seed)} % 23));
            a = (n % 7 == 0) ? $random(seed) : {$random(seed)} % 10;
            b = {$random(seed), $random(seed)};
            i = n[0] ? 32'h000f_01c0 : 32'h000f_01d7;
            if (n % 11 == 0)
                i[23:0] = $random(seed);
            i[30:28] = $random(seed);
            if ({$random(seed)} % 8 == 0)
                i[27:24] = $random(seed);
            run(c, a, i, b);
        end
        complete_run;
    end
    // watchdog against a hang
    initial
    begin
        #(40 * 60000);
        n_fail++;
        complete_run;
    end
endmodule : ecf_enclave_check_tb
`default_nettype wire
